// ==== rtl/port_timer_access.sv ====
// Top: byte-wide peripheral slave holding one I/O port and the shared timer address.
// Assumes the core issues one byte read or write per cycle, synchronous to clk.
`timescale 1ns/10ps
module port_timer_access
#(
    parameter int PORT_W = 8
)
(
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic [port_timer_pkg::ADDR_W-1:0]      busAddr,
    input  wire logic                                   busRead,
    input  wire logic                                   busWrite,
    input  wire logic [port_timer_pkg::DATA_W-1:0]      busWrData,
    output logic      [port_timer_pkg::DATA_W-1:0]      busRdData,
    output logic                                        busRdValid,
    input  wire logic [PORT_W-1:0]                      portPinIn,
    output logic      [PORT_W-1:0]                      portPinOut,
    output logic      [PORT_W-1:0]                      portPinOe
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [PORT_W-1:0]                 port_data_latch;
        logic [PORT_W-1:0]                 port_direction_control;
        logic [port_timer_pkg::DATA_W-1:0] rdData;
        logic                              rdValid;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;

    logic [PORT_W-1:0] portReadValue;

    timer_access_if tmrBus ();

    function automatic logic addrHit
    (
        input logic [port_timer_pkg::ADDR_W-1:0] addr,
        input logic [port_timer_pkg::ADDR_W-1:0] target
    );
        addrHit = (addr == target);
    endfunction : addrHit

    // Reads outside the block answer with a fixed byte, so a stray access
    // never echoes whatever the last answer happened to be.
    function automatic logic [port_timer_pkg::DATA_W-1:0] readAnswer
    (
        input logic                              hitTimer,
        input logic                              hitData,
        input logic                              hitDir,
        input logic [port_timer_pkg::DATA_W-1:0] count,
        input logic [port_timer_pkg::DATA_W-1:0] portValue
    );
        // counter value returned, never the load register
        if (hitTimer)
            readAnswer = count;
        else if (hitData)
            readAnswer = portValue;
        else if (hitDir)
            readAnswer = port_timer_pkg::DIR_READ_VALUE;
        else
            readAnswer = port_timer_pkg::UNMAPPED_READ;
    endfunction : readAnswer

    // ************************************************************
    // Address decode
    // ************************************************************
    logic selTimer;
    logic selData;
    logic selDir;
    logic timerLoadWrite;
    logic latchWrite;
    logic dirWrite;

    always_comb
    begin
        selTimer       = addrHit(busAddr, port_timer_pkg::TIMER_SHARED_ADDR);
        selData        = addrHit(busAddr, port_timer_pkg::PORT_DATA_ADDR);
        selDir         = addrHit(busAddr, port_timer_pkg::PORT_DIR_ADDR);
        timerLoadWrite = busWrite & selTimer;
        latchWrite     = busWrite & selData;
        dirWrite       = busWrite & selDir;
    end

    // ************************************************************
    // Timer
    // ************************************************************
    reload_timer reload_timer_i
    (
        .clk (clk),
        .rst (rst),
        .tmr (tmrBus.timer)
    );

    // shared address write goes to load
    assign tmrBus.loadWrite = timerLoadWrite;
    assign tmrBus.loadData  = busWrData;

    // ************************************************************
    // Port read mix
    // ************************************************************
    // A bit-set on the port writes pin levels back into input latches;
    // this is intended, so software keeps its own copy of the latch byte.
    for (genvar i = 0; i < PORT_W; i++)
    begin : g_read_mix
        assign portReadValue[i] = state.port_direction_control[i]
                                ? state.port_data_latch[i] : portPinIn[i];
    end

    // ************************************************************
    // Register access
    // ************************************************************
    always_comb
    begin
        next_state         = state;
        next_state.rdValid = 1'h0;
        if (busRead)
        begin
            next_state.rdValid = 1'h1;
            next_state.rdData  = readAnswer(selTimer, selData, selDir,
                                            tmrBus.count, portReadValue);
        end
        if (latchWrite)
            next_state.port_data_latch = busWrData;
        if (dirWrite)
            next_state.port_direction_control = busWrData;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state.port_data_latch        <= port_timer_pkg::LATCH_RESET;
            state.port_direction_control <= port_timer_pkg::DIR_RESET;
            state.rdData                 <= port_timer_pkg::READ_DATA_RESET;
            state.rdValid                <= 1'h0;
        end
        else
            state <= next_state;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign busRdData  = state.rdData;
    assign busRdValid = state.rdValid;
    assign portPinOut = state.port_data_latch;
    assign portPinOe  = state.port_direction_control;

endmodule : port_timer_access

// ==== rtl/port_timer_pkg.sv ====
// Package: addresses, widths and reset values of the port and timer byte registers.
// Assumes a 16-bit byte address on the internal peripheral bus.
package port_timer_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ************************************************************
    // Byte addresses
    // ************************************************************
    localparam logic [ADDR_W-1:0] TIMER_SHARED_ADDR  = 16'hFFB3;
    localparam logic [ADDR_W-1:0] PORT_DATA_ADDR     = 16'hFFD6;
    localparam logic [ADDR_W-1:0] PORT_DIR_ADDR      = 16'hFFE6;

    // ************************************************************
    // Read answers, reset values and timer counting constants
    // ************************************************************
    localparam logic [DATA_W-1:0] DIR_READ_VALUE     = 8'hFF;
    localparam logic [DATA_W-1:0] UNMAPPED_READ      = 8'hFF;
    localparam logic [DATA_W-1:0] LATCH_RESET        = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RESET          = 8'h00;
    localparam logic [DATA_W-1:0] TIMER_LOAD_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] TIMER_COUNT_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] TIMER_COUNT_TOP    = 8'hFF;
    localparam logic [DATA_W-1:0] TIMER_STEP         = 8'h01;
    localparam logic [DATA_W-1:0] READ_DATA_RESET    = 8'h00;

endpackage : port_timer_pkg

// ==== rtl/reload_timer.sv ====
// Reloadable 8-bit up counter with a load register at one shared address.
// Assumes the access side writes the load register and reads only the count.
`timescale 1ns/10ps
module reload_timer
(
    input  wire logic       clk,
    input  wire logic       rst,
    timer_access_if.timer   tmr
);

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] load;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;

    always_comb
    begin
        next_state = state;
        // Reload on wrap so the period follows the load register
        if (state.count == port_timer_pkg::TIMER_COUNT_TOP)
            next_state.count = state.load;
        else
            next_state.count = state.count + port_timer_pkg::TIMER_STEP;
        if (tmr.loadWrite)
            next_state.load = tmr.loadData;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state.count <= port_timer_pkg::TIMER_COUNT_RESET;
            state.load  <= port_timer_pkg::TIMER_LOAD_RESET;
        end
        else
            state <= next_state;
    end

    assign tmr.count = state.count;

endmodule : reload_timer

// ==== rtl/timer_access_if.sv ====
// Interface: load-register write and counter readback between port block and timer.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface timer_access_if;
    logic       loadWrite;
    logic [7:0] loadData;
    logic [7:0] count;

    modport access
    (
        output loadWrite,
        output loadData,
        input  count
    );

    modport timer
    (
        input  loadWrite,
        input  loadData,
        output count
    );
endinterface : timer_access_if

// ==== test/core_bus_model.sv ====
// Core model: byte read, write and read-modify-write on the peripheral bus.
// Assumes a read answer one cycle after the request edge.
`timescale 1ns/10ps
module core_bus_model
(
    input wire logic  [7:0]  busRdData,
    input wire logic         busRdValid,
    input wire logic         clk,
    output logic      [15:0] busAddr,
    output logic             busRead,
    output logic             busWrite,
    output logic      [7:0]  busWrData
);
    initial
    begin
        busAddr = 16'h0000;
        busRead = 1'h0;
        busWrite = 1'h0;
        busWrData = 8'h00;
    end
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        busAddr = a;
        busRead = 1'h1;
        @(negedge clk);
        // Missing answer shows up as unknown data
        d = busRdValid ? busRdData : 8'hXX;
        busRead = 1'h0;
        busAddr = ~a;
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        busAddr = a;
        busWrData = v;
        busWrite = 1'h1;
        @(negedge clk);
        busWrite = 1'h0;
        busAddr = ~a;
        busWrData = ~v;
    endtask : wr
    // read, alter one bit, write back
    task automatic rmw(input logic [15:0] a, input int b, input logic s, output logic [7:0] d);
        rd(a, d);
        wr(a, s ? (d | (8'h01 << b)) : (d & ~(8'h01 << b)));
    endtask : rmw
endmodule : core_bus_model

// ==== test/port_timer_access_assertions.sv ====
// Checker: bus answer and pin relations of the port and timer block.
// Assumes it is bound to every instance of port_timer_access.
`timescale 1ns/10ps
module port_timer_access_assertions
#(
    parameter int PORT_W = 8
)
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [15:0]       busAddr,
    input wire logic              busRead,
    input wire logic              busWrite,
    input wire logic [7:0]        busWrData,
    input wire logic [7:0]        busRdData,
    input wire logic              busRdValid,
    input wire logic [PORT_W-1:0] portPinIn,
    input wire logic [PORT_W-1:0] portPinOut,
    input wire logic [PORT_W-1:0] portPinOe
);
    logic isData;
    logic isDir;
    assign isData = busAddr == port_timer_pkg::PORT_DATA_ADDR;
    assign isDir = busAddr == port_timer_pkg::PORT_DIR_ADDR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_read_answered: assert property (busRead |=> busRdValid)
        else $error("read not answered");
    chk_no_answer: assert property (!busRead |=> !busRdValid)
        else $error("answer without read");
    chk_data_held: assert property (!busRead |=> $stable(busRdData))
        else $error("read data moved");
    chk_dir_ones: assert property (busRead && isDir |=> busRdData == 8'hFF)
        else $error("direction read not all ones");
    chk_input_bits: assert property (busRead && isData |=>
        ((busRdData ^ $past(portPinIn)) & ~$past(portPinOe)) == 8'h00)
        else $error("input bit not pin level");
    chk_output_bits: assert property (busRead && isData |=>
        ((busRdData ^ $past(portPinOut)) & $past(portPinOe)) == 8'h00)
        else $error("output bit not latch");
    chk_latch_write: assert property (busWrite && isData |=> portPinOut == $past(busWrData))
        else $error("latch not written");
    chk_dir_write: assert property (busWrite && isDir |=> portPinOe == $past(busWrData))
        else $error("direction not written");
    chk_pin_held: assert property (!(busWrite && isData) |=> $stable(portPinOut))
        else $error("pin level moved");
endmodule : port_timer_access_assertions

bind port_timer_access port_timer_access_assertions #(.PORT_W(PORT_W)) chk_i (.clk(clk),
    .rst(rst), .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite),
    .busWrData(busWrData), .busRdData(busRdData), .busRdValid(busRdValid),
    .portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe));

// ==== test/port_timer_access_tb.sv ====
// Testbench: port read mixing, write-only direction and shared timer address.
// Assumes the core model owns the bus; the bench drives the pins.
`timescale 1ns/10ps
module port_timer_access_tb;
    logic clk;
    logic rst;
    logic [7:0] pinIn;
    logic [15:0] busAddr;
    logic busRead;
    logic busWrite;
    logic [7:0] busWrData;
    logic [7:0] rdData;
    logic rdValid;
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    int errCount = 0;
    int totalChecks = 0;
    int cycles = 0;
    port_timer_access port_timer_access_i (.clk(clk), .rst(rst), .busAddr(busAddr),
        .busRead(busRead), .busWrite(busWrite), .busWrData(busWrData), .busRdData(rdData),
        .busRdValid(rdValid), .portPinIn(pinIn), .portPinOut(pinOut), .portPinOe(pinOe));
    core_bus_model core_bus_model_i (.clk(clk), .busRdData(rdData), .busRdValid(rdValid),
        .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite), .busWrData(busWrData));
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic endOfTest;
        if (errCount == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : endOfTest
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errCount++;
            endOfTest();
        end
    end
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // Pin 6 reads high while its latch holds zero
    task automatic portBits;
        logic [7:0] d;
        check("oe", pinOe, 8'h00);
        pinIn = 8'h7F;
        core_bus_model_i.wr(port_timer_pkg::PORT_DIR_ADDR, 8'h3F);
        core_bus_model_i.wr(port_timer_pkg::PORT_DATA_ADDR, 8'h80);
        core_bus_model_i.rmw(port_timer_pkg::PORT_DATA_ADDR, 0, 1'h1, d);
        check("bitSetRead", d, 8'h40);
        check("latch", pinOut, 8'h41);
        pinIn = 8'h80;
        core_bus_model_i.rmw(port_timer_pkg::PORT_DIR_ADDR, 0, 1'h0, d);
        check("dirRead", d, 8'hFF);
        check("oe", pinOe, 8'hFE);
        check("pins", pinOut, 8'h41);
        core_bus_model_i.rd(port_timer_pkg::PORT_DATA_ADDR, d);
        check("mixRead", d, 8'h40);
        core_bus_model_i.rd(16'h0000, d);
        check("unmapped", d, port_timer_pkg::UNMAPPED_READ);
        core_bus_model_i.wr(16'h0000, 8'hBE);
        check("unmappedWr", pinOut, 8'h41);
        check("unmappedOe", pinOe, 8'hFE);
    endtask : portBits
    function automatic logic [7:0] step(input logic [7:0] c);
        return (c === 8'hFF) ? 8'hF0 : c + 8'h01;
    endfunction : step
    // Reads two cycles apart must follow the count and reload from the load value
    task automatic timerShared;
        logic [7:0] prev;
        logic [7:0] d;
        int wraps = 0;
        core_bus_model_i.wr(port_timer_pkg::TIMER_SHARED_ADDR, 8'hF0);
        core_bus_model_i.rd(port_timer_pkg::TIMER_SHARED_ADDR, prev);
        repeat (300)
        begin
            core_bus_model_i.rd(port_timer_pkg::TIMER_SHARED_ADDR, d);
            check("count", d, step(step(prev)));
            if (d < prev)
                wraps++;
            prev = d;
        end
        check("reloads", (wraps > 0) ? 8'h01 : 8'h00, 8'h01);
    endtask : timerShared
    initial
    begin
        rst = 1'h1;
        pinIn = 8'h00;
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'h0;
        portBits();
        timerShared();
        endOfTest();
    end
endmodule : port_timer_access_tb
